/* File: rtl/bmx_params.svh */
`ifndef BMX_PARAMS_SVH
`define BMX_PARAMS_SVH

// register locations as seen by the host, base address added at integration
`define BMX_OFS_GRP_A   16'hf101
`define BMX_OFS_GRP_B   16'hf102
`define BMX_OFS_GRP_C   16'hf103
`define BMX_OFS_GRP_D   16'hf104
`define BMX_OFS_DIR     16'hf105

// width of the register address input
`define BMX_ADDR_W      3
// pin group geometry
`define BMX_NGRP        4
`define BMX_GRP_W       8

// reset values
`define BMX_OUT_RST     8'h00
`define BMX_DIR_RST     4'h0
`define BMX_RDATA_RST   8'h00

// read value for unmapped or write-only locations
`define BMX_RD_NONE     8'h00

// direction encoding
`define BMX_DIR_OUT     1'b1
`define BMX_DIR_IN      1'b0

`endif

/* File: rtl/bmx_pkg.sv */
`include "bmx_params.svh"

package bmx_pkg;

  typedef logic [`BMX_GRP_W-1:0]  bmx_byte_t;
  typedef logic [`BMX_ADDR_W-1:0] bmx_addr_t;

  // decoded target of a bus access
  typedef enum logic [2:0] {
    BMX_SEL_GRP_A = 3'h0,
    BMX_SEL_GRP_B = 3'h1,
    BMX_SEL_GRP_C = 3'h2,
    BMX_SEL_GRP_D = 3'h3,
    BMX_SEL_DIR   = 3'h4,
    BMX_SEL_NONE  = 3'h7
  } bmx_sel_t;

  // the address input carries the low bits of the full offset
  function automatic bmx_addr_t bmx_idx(input logic [15:0] ofs);
    bmx_idx = ofs[`BMX_ADDR_W-1:0];
  endfunction : bmx_idx

endpackage : bmx_pkg

/* File: rtl/bmx_wr_if.sv */
`timescale 1ns/100ps
`include "bmx_params.svh"

interface bmx_wr_if #(
  parameter int NGRP = `BMX_NGRP,
  parameter int W    = `BMX_GRP_W
);
  logic [NGRP-1:0]        grp_wr;
  logic                   dir_wr;
  logic [W-1:0]           wdata;
  logic [NGRP-1:0][W-1:0] out_val;
  logic [NGRP-1:0]        dir;

  modport drv (output grp_wr, output dir_wr, output wdata, input out_val, input dir);
  modport rcv (input grp_wr, input dir_wr, input wdata, output out_val, output dir);
endinterface : bmx_wr_if

/* File: rtl/bmx_sync.sv */
`timescale 1ns/100ps

module bmx_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // asynchronous pin level in, synchronised level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  // first stage feeds only the second
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
    if (rst) begin
      next_stage1   = '0;
      next_sync_out = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    stage1   <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule : bmx_sync

/* File: rtl/bmx_regfile.sv */
`timescale 1ns/100ps
`include "bmx_params.svh"

module bmx_regfile #(
  parameter int NGRP = `BMX_NGRP,
  parameter int W    = `BMX_GRP_W
) (
  // clock and active-high reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // write strobes in, held values out
  bmx_wr_if.rcv     wif
);

  // per-group reset direction, sized to the group count so each group takes one bit
  localparam logic [NGRP-1:0] DIR_RST = `BMX_DIR_RST;

  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : gen_grp
      logic [W-1:0] out_q;
      logic [W-1:0] next_out_q;
      logic         dir_q;
      logic         next_dir_q;

      always_comb begin
        next_out_q = out_q;
        next_dir_q = dir_q;
        if (rst) begin
          next_out_q = `BMX_OUT_RST;
          next_dir_q = DIR_RST[g];
        end else begin
          if (wif.grp_wr[g]) begin
            next_out_q = wif.wdata;
          end
          if (wif.dir_wr) begin
            next_dir_q = wif.wdata[g];
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        out_q <= next_out_q;
        dir_q <= next_dir_q;
      end

      assign wif.out_val[g] = out_q;
      assign wif.dir[g]     = dir_q;
    end
  endgenerate

endmodule : bmx_regfile

/* File: rtl/bmx_io_expander.sv */
`timescale 1ns/100ps
`include "bmx_params.svh"


module bmx_io_expander #(
  parameter int NGRP = `BMX_NGRP,
  parameter int W    = `BMX_GRP_W
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // host bus
  input  wire logic                   cs,
  input  wire logic                   wr,
  input  wire logic                   rd,
  input  wire logic                   penable,
  input  wire logic [`BMX_ADDR_W-1:0] addr,
  input  wire logic [W-1:0]           write_data,
  output logic      [W-1:0]           read_data,
  // pin groups a..d, index 0 is group a
  input  wire logic [NGRP-1:0][W-1:0] pin_in,
  output logic      [NGRP-1:0][W-1:0] pin_out,
  output logic      [NGRP-1:0][W-1:0] pin_oe_n
);

  logic                    rst;
  bmx_pkg::bmx_sel_t       sel;
  logic [NGRP-1:0][W-1:0]  pin_sync;
  logic [W-1:0]            next_read_data;
  logic                    wr_hit;

  bmx_wr_if #(.NGRP(NGRP), .W(W)) wif ();

  assign rst = ~nrst;

  always_comb begin
    if (addr == bmx_pkg::bmx_idx(`BMX_OFS_GRP_A)) begin
      sel = bmx_pkg::BMX_SEL_GRP_A;
    end else if (addr == bmx_pkg::bmx_idx(`BMX_OFS_GRP_B)) begin
      sel = bmx_pkg::BMX_SEL_GRP_B;
    end else if (addr == bmx_pkg::bmx_idx(`BMX_OFS_GRP_C)) begin
      sel = bmx_pkg::BMX_SEL_GRP_C;
    end else if (addr == bmx_pkg::bmx_idx(`BMX_OFS_GRP_D)) begin
      sel = bmx_pkg::BMX_SEL_GRP_D;
    end else if (addr == bmx_pkg::bmx_idx(`BMX_OFS_DIR)) begin
      sel = bmx_pkg::BMX_SEL_DIR;
    end else begin
      sel = bmx_pkg::BMX_SEL_NONE;
    end
  end

  assign wr_hit      = cs & wr & penable;
  assign wif.dir_wr  = wr_hit & (sel == bmx_pkg::BMX_SEL_DIR);
  // write data straight to the holding registers
  assign wif.wdata   = write_data;

  bmx_regfile #(.NGRP(NGRP), .W(W)) u_regs (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wif     (wif)
  );

  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : gen_grp
      assign wif.grp_wr[g] = wr_hit & (sel == bmx_pkg::bmx_sel_t'(g));

      // pins are asynchronous to clk_sys
      bmx_sync #(.W(W)) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (pin_in[g]),
        .sync_out (pin_sync[g])
      );

      assign pin_out[g]  = wif.out_val[g];
      assign pin_oe_n[g] = {W{wif.dir[g] != `BMX_DIR_OUT}};
    end
  endgenerate

  // read data registered; direction register reads as zero since it is write-only
  always_comb begin
    next_read_data = read_data;
    if (rst) begin
      next_read_data = `BMX_RDATA_RST;
    end else if (cs && rd) begin
      case (sel)
        bmx_pkg::BMX_SEL_GRP_A: next_read_data = pin_sync[0];
        bmx_pkg::BMX_SEL_GRP_B: next_read_data = pin_sync[1];
        bmx_pkg::BMX_SEL_GRP_C: next_read_data = pin_sync[2];
        bmx_pkg::BMX_SEL_GRP_D: next_read_data = pin_sync[3];
        default:                next_read_data = `BMX_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    read_data <= next_read_data;
  end

endmodule : bmx_io_expander

/* File: tb/bmx_io_expander_props.sv */
`timescale 1ns/100ps
`include "bmx_params.svh"

module bmx_io_expander_chk #(
  parameter int NGRP = 4,
  parameter int W    = 8
) (
  // clock, reset and host bus
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  input wire logic                   cs,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic                   penable,
  input wire logic [`BMX_ADDR_W-1:0] addr,
  input wire logic [W-1:0]           write_data,
  input wire logic [W-1:0]           read_data,
  // pin groups
  input wire logic [NGRP-1:0][W-1:0] pin_in,
  input wire logic [NGRP-1:0][W-1:0] pin_out,
  input wire logic [NGRP-1:0][W-1:0] pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wen;
  assign wen = cs && wr && penable;

  property p_wr; wen && addr != 3'h0 && addr < 3'h5 |=> pin_out[$past(addr)-1] == $past(write_data);
  endproperty
  a_wr: assert property (p_wr) else $error("group write lost");
  property p_hold; !wen |=> $stable(pin_out) && $stable(pin_oe_n); endproperty
  a_hold: assert property (p_hold) else $error("pins moved without write");
  property p_dir; wen && addr == 3'h5 |=> pin_oe_n[0] == {W{~$past(write_data[0])}}
    && pin_oe_n[3] == {W{~$past(write_data[3])}}; endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_dirkeep; wen && addr != 3'h5 |=> $stable(pin_oe_n); endproperty
  a_dirkeep: assert property (p_dirkeep) else $error("direction disturbed");
  property p_rdnone; cs && rd && addr == 3'h5 |=> read_data == 8'h00; endproperty
  a_rdnone: assert property (p_rdnone) else $error("direction readable");
  property p_rdhold; !(cs && rd) |=> $stable(read_data); endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  // synchroniser depth is two, so three quiet cycles are enough
  property p_rdpin; $stable(pin_in[1])[*3] ##0 (cs && rd && addr == 3'h2)
    |=> read_data == $past(pin_in[1]); endproperty
  a_rdpin: assert property (p_rdpin) else $error("group b read wrong");
  property p_rst; disable iff (1'b0) !nrst |=> !(|pin_out) && (&pin_oe_n) && read_data == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : bmx_io_expander_chk

bind bmx_io_expander bmx_io_expander_chk #(.NGRP(NGRP), .W(W)) u_chk (.clk_sys, .nrst, .cs,
  .wr, .rd, .penable, .addr, .write_data, .read_data, .pin_in, .pin_out, .pin_oe_n);

/* File: tb/bmx_pin_model.sv */
`timescale 1ns/100ps

module bmx_pin_model #(
  parameter int N = 32
) (
  // far side level, device drive and enable
  input wire logic [N-1:0] ext,
  input wire logic [N-1:0] dout,
  input wire logic [N-1:0] oe_n,
  // resolved wire
  output logic     [N-1:0] pin
);
  assign pin = (oe_n & ext) | (~oe_n & dout);
endmodule : bmx_pin_model

/* File: tb/tb.sv */
`timescale 1ns/100ps

module tb;
  logic            clk_sys = 1'b0;
  logic            nrst = 1'b0;
  logic            cs = 1'b0, wr = 1'b0, rd = 1'b0, penable = 1'b0;
  logic [2:0]      addr = 3'h0;
  logic [7:0]      write_data = 8'h00, read_data;
  logic [3:0][7:0] pin_in, pin_out, pin_oe_n, ext = 32'h0, shadow = 32'h0;
  logic [3:0]      dir = 4'h0;
  logic [2:0]      a;
  int              bad_count = 0, n_tests = 0;

  always #10 clk_sys = ~clk_sys;
  bmx_io_expander u_dut (.clk_sys, .nrst, .cs, .wr, .rd, .penable, .addr, .write_data,
    .read_data, .pin_in, .pin_out, .pin_oe_n);
  bmx_pin_model u_pins (.ext(ext), .dout(pin_out), .oe_n(pin_oe_n), .pin(pin_in));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic s, w, input logic [2:0] ad, input logic [7:0] d, input logic en);
    @(negedge clk_sys);
    {cs, wr, rd, penable, addr, write_data} = {s, w, ~w, en, ad, d};
    @(negedge clk_sys);
    {cs, wr, rd, penable} = 4'h0;
  endtask : bus

  // unmapped and write-only places read as zero
  function automatic logic [7:0] exp_rd(input logic [2:0] ad);
    if (ad == 3'h0 || ad > 3'h4) return 8'h00;
    return dir[ad-1] ? shadow[ad-1] : ext[ad-1];
  endfunction : exp_rd

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    void'($urandom(20));
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    for (int g = 0; g < 4; g++) begin
      check(pin_out[g], 8'h00);
      check(pin_oe_n[g], 8'hff);
    end
    repeat (20) begin
      dir = 4'($urandom);
      ext = 32'($urandom);
      bus(1'b1, 1'b1, 3'h5, {4'($urandom), dir}, 1'b1);
      for (int g = 0; g < 4; g++) begin
        check(pin_oe_n[g], {8{~dir[g]}});
        shadow[g] = 8'($urandom);
        bus(1'b1, 1'b1, 3'(g + 1), shadow[g], 1'b1);
        bus(1'b1, 1'b1, 3'(g + 1), ~shadow[g], 1'b0);
        bus(1'b0, 1'b1, 3'(g + 1), ~shadow[g], 1'b1);
        check(pin_out[g], shadow[g]);
      end
      repeat (4) begin
        a = 3'($urandom);
        bus(1'b1, 1'b0, a, 8'h00, 1'b0);
        check(read_data, exp_rd(a));
      end
    end
    // mid-run reset with groups written; three edges also flush the synchronisers
    nrst = 1'b0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    dir = 4'h0;
    check(read_data, 8'h00);
    for (int g = 0; g < 4; g++) begin
      check(pin_out[g], 8'h00);
      check(pin_oe_n[g], 8'hff);
    end
    bus(1'b1, 1'b1, 3'h5, 8'h00, 1'b1);
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, 1'b0, 3'(g + 1), 8'h00, 1'b0);
      check(read_data, ext[g]);
    end
    bus(1'b0, 1'b0, 3'h1, 8'h00, 1'b0);
    check(read_data, ext[3]);
    conclude();
  end

  // a run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
endmodule : tb
